// >>> hw/clk_gen_ctrl.sv
/*
 clock generation unit control logic: ahb-lite register slave, pll setup
 decode, oscillator stabilisation, main oscillator stop fallback, bus clock
 pin, event link hooks and interrupt.
 assumes all inputs synchronous to hclk; oscillators and pll are analog.
*/
// Function
// - main oscillator stop switches the system clock to the slow oscillator
// - main oscillator stop can force timer output pins to high impedance
// - pll input divider code 0,1,2 divide by 1,2,3; code 3 refused
// - pll source select chooses main oscillator or fast on-chip oscillator
// - multiplier code 0x13..0x3b gives x10.0 to x30.0 in half steps
// - bus clock pin drives the bus clock or holds high
// - driven bus clock pin shows the bus clock or half of it
// - fast oscillator frequency 16, 18 or 20 MHz, with power control
// - an event link output pulse marks main oscillator stop
// - an event link input can switch the source to the slow oscillator
// - sys clock control holds four-bit peripheral a and d divider selects
// - second sys clock control holds a four-bit can-fd divider select
// - pll multiplication 10 to 30, input division 1, 2 or 3
`timescale 1ns/1ps
`default_nettype none

module clk_gen_ctrl
    import clk_gen_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    input  wire logic        slow_tick,
    input  wire logic        main_osc_alive,
    input  wire logic        pll_lock,
    input  wire logic        fast_osc_ready,
    input  wire logic        bclk_edge,
    input  wire logic        evt_in,
    output var  logic        evt_out,
    output var  logic        timer_hiz_req,
    output var  logic        bclk_pin,
    output var  cfg_s        cfg,
    output var  clk_src_e    active_src,
    output var  logic [1:0]  pll_in_div_ratio,
    output var  logic [5:0]  pll_mult_half,
    output var  logic        irq
);

    cfg_s               cfg_reg;
    cfg_s               cfg_next;
    clk_src_e           src_reg;
    clk_src_e           src_next;
    logic               wr_pend_reg;
    logic               wr_pend_next;
    logic [7:0]         waddr_reg;
    logic [7:0]         waddr_next;
    logic [31:0]        hrdata_reg;
    logic [31:0]        hrdata_next;
    logic               hreadyout_reg;
    logic               stopped_reg;
    logic               stopped_next;
    logic               evt_out_reg;
    logic               evt_out_next;
    logic               hiz_reg;
    logic               hiz_next;
    logic [IRQ_W-1:0]   stat_reg;
    logic [IRQ_W-1:0]   stat_next;
    logic [IRQ_W-1:0]   mask_reg;
    logic [IRQ_W-1:0]   mask_next;
    logic               irq_reg;
    logic               irq_next;
    logic               bclk_full_reg;
    logic               bclk_full_next;
    logic               bclk_half_reg;
    logic               bclk_half_next;
    logic               bclk_pin_reg;
    logic               bclk_pin_next;
    logic [1:0]         div_ratio_reg;
    logic [1:0]         div_ratio_next;
    logic [5:0]         mult_half_reg;
    logic [5:0]         mult_half_next;
    logic               main_stable;
    logic               main_stable_d_reg;
    logic               addr_ok;
    logic               stop_hit;
    logic               evt_hit;
    logic               pll_ref_ok;
    logic [IRQ_W-1:0]   stat_set;
    logic [IRQ_W-1:0]   stat_clr;

    // ------------------------------------------------------------
    // stabilisation wait counter
    // ------------------------------------------------------------
    main_osc_wait u_wait (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .enable    (cfg_reg.main_osc_en && !stopped_reg),
        .slow_tick (slow_tick),
        .wait_code (cfg_reg.main_osc_wait_code),
        .stable    (main_stable)
    );

    function automatic logic target_ok(input clk_src_e s, input cfg_s c,
                                       input logic mst, input logic pref);
        unique case (s)
            SRC_SLOW: target_ok = 1'b1;
            SRC_FAST: target_ok = c.fast_osc_pwr && fast_osc_ready;
            SRC_MAIN: target_ok = mst;
            SRC_PLL:  target_ok = c.pll_en && pll_lock && pref;
        endcase
    endfunction : target_ok

    // ------------------------------------------------------------
    // register access
    // ------------------------------------------------------------
    always_comb begin
        addr_ok      = hsel && hready && htrans[1];
        wr_pend_next = addr_ok && hwrite;
        waddr_next   = addr_ok ? haddr[7:0] : waddr_reg;
        cfg_next     = cfg_reg;
        mask_next    = mask_reg;
        stat_clr     = '0;
        hrdata_next  = 32'h0000_0000;
        if (addr_ok && !hwrite) begin
            unique case (haddr[7:0])
                OFF_SYS_CLK: begin
                    hrdata_next[SCK_PERIPH_D_DIV_SEL_LSB +: 4] = cfg_reg.periph_d_div_sel;
                    hrdata_next[SCK_PERIPH_A_DIV_SEL_LSB +: 4] = cfg_reg.periph_a_div_sel;
                    hrdata_next[SCK_BCLK_HIGH]     = cfg_reg.bclk_high;
                    hrdata_next[SCK_BCLK_HALF]     = cfg_reg.bclk_half;
                end
                OFF_SYS_CLK2: hrdata_next[SCK2_CANFD_DIV_SEL_LSB +: 4] = cfg_reg.canfd_div_sel;
                OFF_PLL: begin
                    hrdata_next[PLL_DIV_LSB +: 2]  = cfg_reg.pll_in_div_sel;
                    hrdata_next[PLL_SRC_BIT]       = cfg_reg.pll_src_sel_a;
                    hrdata_next[PLL_MULT_LSB +: 6] = cfg_reg.pll_mult_code;
                end
                OFF_MOSC_WAIT: hrdata_next[7:0] = cfg_reg.main_osc_wait_code;
                OFF_SRC_CTRL: begin
                    hrdata_next[SRC_REQ_LSB +: 2]   = cfg_reg.src_req;
                    hrdata_next[SRC_MOSC_EN]        = cfg_reg.main_osc_en;
                    hrdata_next[SRC_PLL_EN]         = cfg_reg.pll_en;
                    hrdata_next[SRC_FAST_PWR]       = cfg_reg.fast_osc_pwr;
                    hrdata_next[SRC_FAST_FREQ +: 2] = cfg_reg.fast_osc_freq;
                    hrdata_next[SRC_STOP_DET]       = cfg_reg.stop_det_en;
                    hrdata_next[SRC_STOP_HIZ]       = cfg_reg.stop_hiz_en;
                    hrdata_next[SRC_EVT_SW]         = cfg_reg.evt_switch_en;
                end
                OFF_STABLE: hrdata_next[5:0] = {src_reg, stopped_reg,
                                                fast_osc_ready, pll_lock,
                                                main_stable};
                OFF_IRQ_STAT: begin
                    hrdata_next[IRQ_W-1:0] = stat_reg;
                    stat_clr               = stat_reg;
                end
                OFF_IRQ_MASK: hrdata_next[IRQ_W-1:0] = mask_reg;
                default: hrdata_next = 32'h0000_0000;
            endcase
        end
        if (wr_pend_reg) begin
            unique case (waddr_reg)
                OFF_SYS_CLK: begin
                    cfg_next.periph_d_div_sel = hwdata[SCK_PERIPH_D_DIV_SEL_LSB +: 4];
                    cfg_next.periph_a_div_sel = hwdata[SCK_PERIPH_A_DIV_SEL_LSB +: 4];
                    cfg_next.bclk_high        = hwdata[SCK_BCLK_HIGH];
                    cfg_next.bclk_half        = hwdata[SCK_BCLK_HALF];
                end
                OFF_SYS_CLK2: cfg_next.canfd_div_sel = hwdata[SCK2_CANFD_DIV_SEL_LSB +: 4];
                OFF_PLL: begin
                    if (hwdata[PLL_DIV_LSB +: 2] != PLL_DIV_BAD) begin
                        cfg_next.pll_in_div_sel = hwdata[PLL_DIV_LSB +: 2];
                    end
                    cfg_next.pll_src_sel_a = hwdata[PLL_SRC_BIT];
                    if (hwdata[PLL_MULT_LSB +: 6] >= PLL_MULT_MIN &&
                        hwdata[PLL_MULT_LSB +: 6] <= PLL_MULT_MAX) begin
                        cfg_next.pll_mult_code = hwdata[PLL_MULT_LSB +: 6];
                    end
                end
                OFF_MOSC_WAIT: cfg_next.main_osc_wait_code = hwdata[7:0];
                OFF_SRC_CTRL: begin
                    cfg_next.src_req      = clk_src_e'(hwdata[SRC_REQ_LSB +: 2]);
                    cfg_next.main_osc_en  = hwdata[SRC_MOSC_EN];
                    cfg_next.pll_en       = hwdata[SRC_PLL_EN];
                    cfg_next.fast_osc_pwr = hwdata[SRC_FAST_PWR];
                    if (hwdata[SRC_FAST_FREQ +: 2] != FAST_FREQ_BAD) begin
                        cfg_next.fast_osc_freq = hwdata[SRC_FAST_FREQ +: 2];
                    end
                    cfg_next.stop_det_en   = hwdata[SRC_STOP_DET];
                    cfg_next.stop_hiz_en   = hwdata[SRC_STOP_HIZ];
                    cfg_next.evt_switch_en = hwdata[SRC_EVT_SW];
                end
                OFF_IRQ_MASK: mask_next = hwdata[IRQ_W-1:0];
                default: mask_next = mask_reg;
            endcase
        end
        // ------------------------------------------------------------
        // stop detection, event input and source switching
        // ------------------------------------------------------------
        stop_hit = cfg_reg.stop_det_en && main_stable && !main_osc_alive &&
                   !stopped_reg;
        evt_hit  = cfg_reg.evt_switch_en && evt_in;
        stopped_next = cfg_reg.stop_det_en && (stopped_reg || stop_hit);
        evt_out_next = stop_hit;
        hiz_next     = stopped_next && cfg_reg.stop_hiz_en;
        if (stop_hit || evt_hit) begin
            cfg_next.src_req = SRC_SLOW;
        end
        pll_ref_ok = cfg_reg.pll_src_sel_a ? fast_osc_ready : main_stable;
        src_next   = src_reg;
        if (stop_hit || evt_hit) begin
            src_next = SRC_SLOW;
        end else if (cfg_reg.src_req != src_reg &&
                     target_ok(cfg_reg.src_req, cfg_reg, main_stable, pll_ref_ok)) begin
            src_next = cfg_reg.src_req;
        end
        // ------------------------------------------------------------
        // interrupt status, set wins over read clear
        // ------------------------------------------------------------
        stat_set = '0;
        stat_set[IRQ_STOP]     = stop_hit;
        stat_set[IRQ_MOSC_RDY] = main_stable && !main_stable_d_reg;
        stat_set[IRQ_EVT_SW]   = evt_hit;
        stat_next = (stat_reg & ~stat_clr) | stat_set;
        irq_next  = |(stat_next & mask_next);
        // ------------------------------------------------------------
        // bus clock pin and pll decode
        // ------------------------------------------------------------
        bclk_full_next = bclk_edge ? !bclk_full_reg : bclk_full_reg;
        bclk_half_next = (bclk_edge && bclk_full_reg) ? !bclk_half_reg : bclk_half_reg;
        bclk_pin_next  = cfg_next.bclk_high ? 1'b1 :
                         (cfg_next.bclk_half ? bclk_half_next : bclk_full_next);
        div_ratio_next = cfg_next.pll_in_div_sel + 2'h1;
        mult_half_next = cfg_next.pll_mult_code + 6'h01;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_reg           <= CFG_RST;
            src_reg           <= SRC_SLOW;
            wr_pend_reg       <= 1'b0;
            waddr_reg         <= 8'h00;
            hrdata_reg        <= 32'h0000_0000;
            hreadyout_reg     <= 1'b0;
            stopped_reg       <= 1'b0;
            evt_out_reg       <= 1'b0;
            hiz_reg           <= 1'b0;
            stat_reg          <= '0;
            mask_reg          <= '0;
            irq_reg           <= 1'b0;
            bclk_full_reg     <= 1'b0;
            bclk_half_reg     <= 1'b0;
            bclk_pin_reg      <= 1'b1;
            div_ratio_reg     <= 2'h1;
            mult_half_reg     <= PLL_MULT_RST + 6'h01;
            main_stable_d_reg <= 1'b0;
        end else begin
            cfg_reg           <= cfg_next;
            src_reg           <= src_next;
            wr_pend_reg       <= wr_pend_next;
            waddr_reg         <= waddr_next;
            hrdata_reg        <= hrdata_next;
            hreadyout_reg     <= 1'b1;
            stopped_reg       <= stopped_next;
            evt_out_reg       <= evt_out_next;
            hiz_reg           <= hiz_next;
            stat_reg          <= stat_next;
            mask_reg          <= mask_next;
            irq_reg           <= irq_next;
            bclk_full_reg     <= bclk_full_next;
            bclk_half_reg     <= bclk_half_next;
            bclk_pin_reg      <= bclk_pin_next;
            div_ratio_reg     <= div_ratio_next;
            mult_half_reg     <= mult_half_next;
            main_stable_d_reg <= main_stable;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hrdata           = hrdata_reg;
    assign hreadyout        = hreadyout_reg;
    assign hresp            = 1'b0;
    assign evt_out          = evt_out_reg;
    assign timer_hiz_req    = hiz_reg;
    assign bclk_pin         = bclk_pin_reg;
    assign cfg              = cfg_reg;
    assign active_src       = src_reg;
    assign pll_in_div_ratio = div_ratio_reg;
    assign pll_mult_half    = mult_half_reg;
    assign irq              = irq_reg;

endmodule : clk_gen_ctrl

`default_nettype wire

// >>> hw/clk_gen_pkg.sv
/*
 clock generation unit: register offsets, field positions, reset values,
 clock source enumeration and the packed configuration carrier.
 assumes a 32-bit ahb-lite register bus with word-aligned registers.
*/
package clk_gen_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses, low eight address bits)
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_SYS_CLK   = 8'h00;
    localparam logic [7:0] OFF_SYS_CLK2  = 8'h04;
    localparam logic [7:0] OFF_PLL       = 8'h08;
    localparam logic [7:0] OFF_MOSC_WAIT = 8'h0c;
    localparam logic [7:0] OFF_SRC_CTRL  = 8'h10;
    localparam logic [7:0] OFF_STABLE    = 8'h14;
    localparam logic [7:0] OFF_IRQ_STAT  = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK  = 8'h1c;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SCK_PERIPH_D_DIV_SEL_LSB   = 0;
    localparam int SCK_PERIPH_A_DIV_SEL_LSB   = 12;
    localparam int SCK_BCLK_HIGH  = 16;
    localparam int SCK_BCLK_HALF  = 17;
    localparam int SCK2_CANFD_DIV_SEL_LSB = 0;
    localparam int PLL_DIV_LSB    = 0;
    localparam int PLL_SRC_BIT    = 4;
    localparam int PLL_MULT_LSB   = 8;
    localparam int SRC_REQ_LSB    = 0;
    localparam int SRC_MOSC_EN    = 2;
    localparam int SRC_PLL_EN     = 3;
    localparam int SRC_FAST_PWR   = 4;
    localparam int SRC_FAST_FREQ  = 5;
    localparam int SRC_STOP_DET   = 7;
    localparam int SRC_STOP_HIZ   = 8;
    localparam int SRC_EVT_SW     = 9;
    localparam int IRQ_STOP       = 0;
    localparam int IRQ_MOSC_RDY   = 1;
    localparam int IRQ_EVT_SW     = 2;
    localparam int IRQ_W          = 3;

    // ------------------------------------------------------------
    // legal codes and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] PLL_DIV_BAD   = 2'h3;
    localparam logic [5:0] PLL_MULT_MIN  = 6'h13;
    localparam logic [5:0] PLL_MULT_MAX  = 6'h3b;
    localparam logic [1:0] FAST_FREQ_BAD = 2'h3;
    localparam logic [5:0] PLL_MULT_RST  = 6'h13;
    localparam logic [7:0] MOSC_WAIT_RST = 8'hff;
    localparam int         MOSC_WAIT_SHIFT = 5;
    localparam int         MOSC_CNT_W    = 13;

    typedef enum logic [1:0] {
        SRC_SLOW,
        SRC_FAST,
        SRC_MAIN,
        SRC_PLL
    } clk_src_e;

    typedef struct packed {
        logic [3:0] periph_a_div_sel;
        logic [3:0] periph_d_div_sel;
        logic       bclk_high;
        logic       bclk_half;
        logic [3:0] canfd_div_sel;
        logic [1:0] pll_in_div_sel;
        logic       pll_src_sel_a;
        logic [5:0] pll_mult_code;
        logic [7:0] main_osc_wait_code;
        clk_src_e   src_req;
        logic       main_osc_en;
        logic       pll_en;
        logic       fast_osc_pwr;
        logic [1:0] fast_osc_freq;
        logic       stop_det_en;
        logic       stop_hiz_en;
        logic       evt_switch_en;
    } cfg_s;

    localparam cfg_s CFG_RST = '{
        periph_a_div_sel:   4'h0,
        periph_d_div_sel:   4'h0,
        bclk_high:          1'b0,
        bclk_half:          1'b0,
        canfd_div_sel:      4'h0,
        pll_in_div_sel:     2'h0,
        pll_src_sel_a:      1'b0,
        pll_mult_code:      PLL_MULT_RST,
        main_osc_wait_code: MOSC_WAIT_RST,
        src_req:            SRC_SLOW,
        main_osc_en:        1'b0,
        pll_en:             1'b0,
        fast_osc_pwr:       1'b0,
        fast_osc_freq:      2'h0,
        stop_det_en:        1'b0,
        stop_hiz_en:        1'b0,
        evt_switch_en:      1'b0
    };

endpackage : clk_gen_pkg

// >>> hw/main_osc_wait.sv
/*
 main oscillator stabilisation wait counter.
 assumes slow_tick is a one-cycle pulse per slow on-chip oscillator cycle.
*/
`timescale 1ns/1ps
`default_nettype none

module main_osc_wait
    import clk_gen_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       enable,
    input  wire logic       slow_tick,
    input  wire logic [7:0] wait_code,
    output var  logic       stable
);

    logic [MOSC_CNT_W-1:0] cnt_reg;
    logic [MOSC_CNT_W-1:0] cnt_next;
    logic                  stable_reg;
    logic                  stable_next;
    logic [MOSC_CNT_W-1:0] target;

    // ------------------------------------------------------------
    // count slow oscillator cycles after enable
    // ------------------------------------------------------------
    always_comb begin
        target      = MOSC_CNT_W'({wait_code, 5'h00});
        cnt_next    = cnt_reg;
        stable_next = stable_reg;
        if (!enable) begin
            cnt_next    = '0;
            stable_next = 1'b0;
        end else if (!stable_reg && slow_tick) begin
            if (cnt_reg >= target) begin
                stable_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + MOSC_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg    <= '0;
            stable_reg <= 1'b0;
        end else begin
            cnt_reg    <= cnt_next;
            stable_reg <= stable_next;
        end
    end

    assign stable = stable_reg;

endmodule : main_osc_wait

`default_nettype wire

// >>> verif/clk_gen_ctrl_asserts.sv
/*
 checker for clk_gen_ctrl, bound to its ports.
 assumes the clk_gen_pkg layout and a single hclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module clk_gen_ctrl_asserts
    import clk_gen_pkg::*;
(
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       main_osc_alive,
    input wire logic       pll_lock,
    input wire logic       bclk_edge,
    input wire logic       evt_in,
    input wire logic       evt_out,
    input wire logic       timer_hiz_req,
    input wire logic       bclk_pin,
    input wire cfg_s       cfg,
    input wire clk_src_e   active_src,
    input wire logic [1:0] pll_in_div_ratio,
    input wire logic [5:0] pll_mult_half
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_full; (!cfg.bclk_high && !cfg.bclk_half) [*2]; endsequence
    sequence s_high; cfg.bclk_high [*2]; endsequence
    sequence s_evt; evt_in && cfg.evt_switch_en; endsequence
    property p_fall; evt_out |-> active_src == SRC_SLOW && cfg.src_req == SRC_SLOW; endproperty
    a_fall: assert property (p_fall) else $error("no fallback on stop");
    property p_cause; evt_out |-> $past(cfg.stop_det_en) && !$past(main_osc_alive); endproperty
    a_cause: assert property (p_cause) else $error("stop event without cause");
    property p_hiz; evt_out && cfg.stop_hiz_en && $past(cfg.stop_hiz_en) |-> timer_hiz_req; endproperty
    a_hiz: assert property (p_hiz) else $error("no hiz request on stop");
    property p_div; cfg.pll_in_div_sel != PLL_DIV_BAD; endproperty
    a_div: assert property (p_div) else $error("bad divider code stored");
    property p_ratio; $stable(cfg.pll_in_div_sel) |-> pll_in_div_ratio == cfg.pll_in_div_sel + 2'h1; endproperty
    a_ratio: assert property (p_ratio) else $error("divide ratio wrong");
    property p_mult;
        $stable(cfg.pll_mult_code) |-> pll_mult_half == cfg.pll_mult_code + 6'h1
            && cfg.pll_mult_code inside {[PLL_MULT_MIN:PLL_MULT_MAX]};
    endproperty
    a_mult: assert property (p_mult) else $error("multiplier wrong");
    property p_freq; cfg.fast_osc_freq != FAST_FREQ_BAD; endproperty
    a_freq: assert property (p_freq) else $error("bad fast osc code");
    property p_pll; $rose(active_src == SRC_PLL) |-> $past(pll_lock) && $past(cfg.pll_en); endproperty
    a_pll: assert property (p_pll) else $error("pll selected unlocked");
    property p_bfull; s_full ##0 $past(bclk_edge) |-> bclk_pin != $past(bclk_pin); endproperty
    a_bfull: assert property (p_bfull) else $error("bus clock pin missed edge");
    property p_bhigh; s_high |-> bclk_pin; endproperty
    a_bhigh: assert property (p_bhigh) else $error("bus clock pin not high");
    property p_evt; s_evt |=> active_src == SRC_SLOW && cfg.src_req == SRC_SLOW; endproperty
    a_evt: assert property (p_evt) else $error("event did not switch");
endmodule : clk_gen_ctrl_asserts
bind clk_gen_ctrl clk_gen_ctrl_asserts u_chk (.hclk, .hresetn, .main_osc_alive, .pll_lock, .bclk_edge,
    .evt_in, .evt_out, .timer_hiz_req, .bclk_pin, .cfg, .active_src, .pll_in_div_ratio, .pll_mult_half);
`default_nettype wire

// >>> verif/clk_gen_ctrl_bench.sv
/*
 self-checking bench for clk_gen_ctrl over ahb-lite.
 assumes zero wait states and the map of clk_gen_pkg.
*/
`timescale 1ns/1ps
`default_nettype none
module clk_gen_ctrl_bench import clk_gen_pkg::*; ;
    logic        hclk, hresetn = 0, hsel = 0, hwrite = 0, slow_tick = 0, main_osc_alive = 1;
    logic        pll_lock = 0, fast_osc_ready = 1, bclk_edge = 0, evt_in = 0;
    logic        hready, hreadyout, hresp, evt_out, timer_hiz_req, bclk_pin, irq;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0, pll_in_div_ratio;
    logic [2:0]  hsize = 3'h2;
    logic [5:0]  pll_mult_half;
    cfg_s        cfg;
    clk_src_e    active_src;
    int          errors = 0, check_count = 0, cyc = 0;
    assign hready = hreadyout;
    clk_gen_ctrl uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
        .hrdata, .hreadyout, .hresp, .slow_tick, .main_osc_alive, .pll_lock, .fast_osc_ready,
        .bclk_edge, .evt_in, .evt_out, .timer_hiz_req, .bclk_pin, .cfg, .active_src,
        .pll_in_div_ratio, .pll_mult_half, .irq);
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        bus(a, 1'b0, 32'h0);
        check(rd, e);
    endtask : rdc
    task automatic wait_n(input int k);
        repeat (k) @(posedge hclk);
    endtask : wait_n
    task automatic tick(input int k);
        repeat (k) begin
            slow_tick <= 1'b1;
            @(posedge hclk);
            slow_tick <= 1'b0;
            @(posedge hclk);
        end
    endtask : tick
    task automatic bclk_run(input logic [31:0] mode, input int e);
        logic p;
        int   c;
        wr(OFF_SYS_CLK, mode);
        wait_n(2);
        p = bclk_pin;
        c = 0;
        for (int i = 0; i < 18; i++) begin
            bclk_edge <= (i < 16) && i[0];
            @(posedge hclk);
            if (bclk_pin !== p) c++;
            p = bclk_pin;
        end
        check(c, e);
    endtask : bclk_run
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rdc(OFF_SYS_CLK, 32'h0);
        rdc(OFF_PLL, 32'h1300);
        rdc(OFF_MOSC_WAIT, 32'hff);
        wr(8'h20, 32'hffffffff);
        rdc(8'h20, 32'h0);
        wr(OFF_SYS_CLK, 32'ha005);
        rdc(OFF_SYS_CLK, 32'ha005);
        wr(OFF_SYS_CLK2, 32'h7);
        rdc(OFF_SYS_CLK2, 32'h7);
        wr(OFF_PLL, 32'h3b12);
        rdc(OFF_PLL, 32'h3b12);
        check({30'h0, pll_in_div_ratio}, 32'h3);
        check({26'h0, pll_mult_half}, 32'd60);
        wr(OFF_PLL, 32'h1213);
        rdc(OFF_PLL, 32'h3b12);
        wr(OFF_PLL, 32'h3c10);
        rdc(OFF_PLL, 32'h3b10);
        wr(OFF_PLL, 32'h1311);
        wait_n(1);
        check({24'h0, pll_mult_half, pll_in_div_ratio}, {24'h0, 6'd20, 2'd2});
        for (int c = 0; c < 4; c++) begin
            wr(OFF_SRC_CTRL, c << 5);
            wait_n(1);
            check({30'h0, cfg.fast_osc_freq}, (c == 3) ? 2 : c);
        end
    endtask : t_regs
    task automatic t_osc();
        wr(OFF_IRQ_MASK, 32'h2);
        wr(OFF_MOSC_WAIT, 32'h2);
        wr(OFF_SRC_CTRL, 32'h6);
        tick(64);
        rdc(OFF_STABLE, 32'h4);
        tick(1);
        wait_n(4);
        rdc(OFF_STABLE, 32'h25);
        check({30'h0, hresp, irq}, 32'h1);
        rdc(OFF_IRQ_STAT, 32'h2);
        wait_n(2);
        check({31'h0, irq}, 32'h0);
        wr(OFF_SRC_CTRL, 32'h186);
        main_osc_alive <= 1'b0;
        wait_n(2);
        check({31'h0, evt_out}, 32'h1);
        wait_n(6);
        rdc(OFF_STABLE, 32'hc);
        check({30'h0, timer_hiz_req, irq}, 32'h2);
        rdc(OFF_IRQ_STAT, 32'h1);
        main_osc_alive <= 1'b1;
        wr(OFF_SRC_CTRL, 32'h211);
        wait_n(4);
        rdc(OFF_STABLE, 32'h14);
        evt_in <= 1'b1;
        @(posedge hclk);
        evt_in <= 1'b0;
        wait_n(2);
        rdc(OFF_SRC_CTRL, 32'h210);
        rdc(OFF_IRQ_STAT, 32'h4);
        wr(OFF_SRC_CTRL, 32'h1b);
        wait_n(4);
        rdc(OFF_STABLE, 32'h4);
        pll_lock <= 1'b1;
        wait_n(4);
        rdc(OFF_STABLE, 32'h36);
    endtask : t_osc
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_osc();
        bclk_run(32'h0, 8);
        bclk_run(32'h20000, 4);
        bclk_run(32'h10000, 0);
        print_verdict();
    end
endmodule : clk_gen_ctrl_bench
`default_nettype wire
